// ==== rtl/dsq_fifo.sv ====
// Sample FIFO with a registered output word
`timescale 1ns/10ps
`default_nettype none
module dsq_fifo
	import dsq_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)(
	input wire logic core_clk, // Clock
	input wire logic nrst, // Async reset, low
	input wire logic ce, // Clock enable
	input wire logic flush, // Drop all content
	input wire logic inValid, // Write request
	input wire logic [WIDTH-1:0] inData, // Write word
	output logic inReady, // Room for a word
	output logic outValid, // Output word held
	output logic [WIDTH-1:0] outData, // Output word
	input wire logic outReady, // Reader takes word
	output logic [$clog2(DEPTH):0] fill // Words held
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] memCount;
		logic valid;
		logic [WIDTH-1:0] data;
	} dsq_fifo_s;

	dsq_fifo_s r;
	dsq_fifo_s next_r;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// ==========================================
	// Handshake terms; the held output word counts toward full
	assign fill = r.memCount + {{AW{1'b0}}, r.valid};
	assign inReady = (fill != (AW+1)'(DEPTH));
	assign push = inValid && inReady && !flush;
	assign pop = (r.memCount != '0) && (!r.valid || outReady) && !flush;
	assign outValid = r.valid;
	assign outData = r.data;

	// Pointer and output stage update
	always_comb
	begin
		next_r = r;
		if (r.valid && outReady)
			next_r.valid = 1'b0;
		if (pop)
		begin
			next_r.valid = 1'b1;
			next_r.data = mem[r.rdPtr];
			next_r.rdPtr = r.rdPtr + 1'b1;
		end
		if (push)
			next_r.wrPtr = r.wrPtr + 1'b1;
		next_r.memCount = r.memCount + (AW+1)'(push) - (AW+1)'(pop);
		if (flush)
		begin
			next_r = '0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			r <= '0;
		else if (ce)
			r <= next_r;
	end

	// Storage has no reset; pointers guard it
	always_ff @(posedge core_clk)
	begin
		if (ce && push)
			mem[r.wrPtr] <= inData;
	end
endmodule
`default_nettype wire

// ==== rtl/dsq_pkg.sv ====
// Shared constants and carrier types for the scan sequencer
package dsq_pkg;
	// ==========================================
	// Register offsets and sizes
	localparam logic [2:0] SEQ_PORT_OFS = 3'h1;
	localparam logic [2:0] CFG_OFS = 3'h2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int SEQ_DEPTH = 2048;
	localparam int SAMPLE_WORDS = 2048;
	localparam int THR_DEFAULT = 7;
	localparam int BYTES_PER_SAMPLE = 2;
	localparam logic [3:0] GND_CH_MIN = 4'h8;
	localparam logic [1:0] PACE_EXT = 2'h0;

	// ==========================================
	// Scan states
	typedef enum logic [2:0] {
		DSQ_IDLE,
		DSQ_ARMED,
		DSQ_FETCH,
		DSQ_LOAD,
		DSQ_CONVERT,
		DSQ_PACE
	} dsq_state_e;

	// ==========================================
	// Field layouts, msb first
	typedef struct packed {
		logic spare;
		logic diffMode;
		logic [1:0] gain;
		logic [3:0] channel;
		logic firstMark;
		logic syncHold;
		logic [1:0] extGain;
		logic [3:0] extChannel;
	} dsq_entry_s;

	typedef struct packed {
		logic [1:0] pacerSrc;
		logic expMode;
		logic endIntEn;
		logic thrIntEn;
		logic continuous;
		logic extTrig;
		logic fallEdge;
	} dsq_cfg_s;

	typedef struct packed {
		logic idle;
		logic triggered;
		logic lost;
		logic endPass;
		logic thr;
		logic full;
		logic almostFull;
		logic empty;
	} dsq_status_s;
endpackage

// ==== rtl/dsq_sequencer.sv ====
// Scan sequencer: sequence memory, control word, status word, pass control
// ==========================================
// Contract
// R1: No samples held: empty set, almost-full and full clear; low fill: all clear.
// R2: Fill at threshold sets almost-full; 4096 bytes also sets full; empty clear.
// R3: Sequence memory holds 2048 sixteen-bit entries written as byte pairs.
// R4: Host writes each entry low byte first, then high byte.
// R5: Entry bit 14 selects differential; bit 15 unused, written as zero.
// R6: Entry bits 13-12 select on-card gain 1, 2, 4, 8.
// R7: Entry bits 11-8 select the on-card input channel.
// R8: Host marks only the first entry with bit 7 set.
// R9: Expansion gain and channel fields ignored without an expansion card.
// R10: Differential with channel 8 or above grounds the converter input.
// R11: Host writes entries only while idle, after flushing the sequence.
// R12: Control bits 7-6 pick the pacer clock source.
// R13: Expansion mode drives digital outputs and gain lines from the entry.
// R14: Control bit 4 gates the end-of-pass interrupt.
// R15: Control bit 3 gates the threshold interrupt.
// R16: Events latch even while their interrupt is disabled.
// R17: One-shot mode: each trigger starts exactly one pass.
// R18: Continuous mode: trigger starts, pacer ticks repeat passes until stop.
// R19: Control bit 1 selects external or software trigger.
// R20: Control bit 0 selects falling or rising external edge.
// R21: Control offset reads return status; writes change control only.
// R22: Status bits report idle, triggered, lost, end, threshold, full, almost-full.
// R23: Status bit 0 reports sample FIFO empty.
// R24: Event bits hold until a status read clears all three.
// R25: A pass walks entries in write order from the marked entry.
`timescale 1ns/10ps
`default_nettype none
module dsq_sequencer
	import dsq_pkg::*;
#(
	parameter int SEQ_WORDS = SEQ_DEPTH,
	parameter int FIFO_WORDS = SAMPLE_WORDS,
	parameter int THR_BYTES = THR_DEFAULT
)(
	input wire logic core_clk, // 20 MHz clock
	input wire logic nrst, // Async reset, low
	input wire logic ce, // Clock enable
	input wire logic [2:0] hostAddr, // Port offset
	input wire logic [7:0] hostWrData, // Write byte
	input wire logic hostWr, // Write strobe
	input wire logic hostRd, // Read strobe
	output logic [7:0] hostRdData, // Read byte
	input wire logic cmdTrigger, // Trigger or arm
	input wire logic cmdStop, // Stop acquisition
	input wire logic cmdFlushSeq, // Flush sequence
	input wire logic cmdFlushData, // Flush samples
	input wire logic extTrigIn, // External trigger line
	input wire logic pacerTick, // Pacer pulse
	output logic convStart, // Start conversion
	input wire logic convDone, // Result ready
	input wire logic [15:0] convData, // Result word
	output logic [3:0] adcChannel, // On-card channel
	output logic [1:0] adcGain, // On-card gain code
	output logic diffMode, // Differential input
	output logic groundInput, // Converter input grounded
	input wire logic [3:0] digOutLatch, // Plain digital out value
	output logic [3:0] digOut, // Digital output lines
	output logic [1:0] expGainOut, // Expansion gain lines
	output logic expGainOe, // Gain lines driven
	output logic [1:0] pacerSource, // Pacer clock source
	output logic [15:0] sampleData, // Sample word
	output logic sampleValid, // Sample available
	input wire logic sampleReady, // Sample taken
	output logic intReq // Interrupt request
);
	localparam int SW = $clog2(SEQ_WORDS);
	localparam int FW = $clog2(FIFO_WORDS);

	typedef struct packed {
		dsq_state_e st;
		dsq_cfg_s cfg;
		logic [7:0] lowByte;
		logic highPhase;
		logic [SW:0] seqLen;
		logic [SW-1:0] markIdx;
		logic markSeen;
		logic [SW-1:0] idx;
		logic triggered;
		logic trigPrev;
		logic afullPrev;
		logic evLost;
		logic evEnd;
		logic evThr;
		dsq_entry_s entry;
		logic convStart;
		logic [7:0] rdData;
		logic intReq;
		logic [3:0] digOut;
		logic groundIn;
		logic [1:0] expGain;
	} dsq_core_s;

	dsq_core_s r;
	dsq_core_s next_r;
	logic [15:0] seqMem [SEQ_WORDS];
	logic [15:0] memQ;
	logic seqWe;
	logic push;
	logic fifoReady;
	logic [FW:0] fill;
	logic [FW+1:0] fillBytes;
	dsq_status_s stat;
	logic trigEdge;
	logic startPass;
	logic lastEntry;

	// ==========================================
	// Sample FIFO; a full FIFO refuses the result and flags loss
	assign push = (r.st == DSQ_CONVERT) && convDone && fifoReady;

	dsq_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_WORDS)
	) u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.flush(cmdFlushData),
		.inValid(push),
		.inData(convData),
		.inReady(fifoReady),
		.outValid(sampleValid),
		.outData(sampleData),
		.outReady(sampleReady),
		.fill(fill)
	);

	// ==========================================
	// Live status word, flags from the byte fill
	always_comb
	begin
		fillBytes = (FW+2)'(fill) * (FW+2)'(BYTES_PER_SAMPLE);
		stat.idle = (r.st == DSQ_IDLE) || (r.st == DSQ_ARMED) || (r.st == DSQ_PACE); // [R22]
		stat.triggered = r.triggered; // [R22]
		stat.lost = r.evLost;
		stat.endPass = r.evEnd;
		stat.thr = r.evThr;
		stat.empty = (fill == '0); // [R1] [R23]
		stat.almostFull = (fillBytes >= (FW+2)'(THR_BYTES)); // [R2]
		stat.full = (fillBytes == (FW+2)'(FIFO_WORDS * BYTES_PER_SAMPLE)); // [R2]
	end

	// Trigger qualification by source and edge
	always_comb
	begin
		trigEdge = r.cfg.fallEdge ? (r.trigPrev && !extTrigIn) : (!r.trigPrev && extTrigIn); // [R20]
		startPass = r.cfg.extTrig ? ((r.st == DSQ_ARMED) && trigEdge)
			: ((r.st == DSQ_IDLE) && cmdTrigger); // [R19]
		lastEntry = ((SW+1)'(r.idx) + 1'b1 >= r.seqLen);
	end

	// Only a completed byte pair while idle lands in memory
	assign seqWe = hostWr && (hostAddr == SEQ_PORT_OFS) && r.highPhase
		&& (r.st == DSQ_IDLE) && (r.seqLen < (SW+1)'(SEQ_WORDS)); // [R3] [R4] [R11]

	// ==========================================
	// Next-state logic
	always_comb
	begin
		next_r = r;
		next_r.convStart = 1'b0;
		next_r.trigPrev = extTrigIn;
		next_r.afullPrev = stat.almostFull;
		// Host writes: control word, sequence bytes
		if (hostWr && hostAddr == CFG_OFS)
			next_r.cfg = dsq_cfg_s'(hostWrData); // [R21]
		if (hostWr && hostAddr == SEQ_PORT_OFS && r.st == DSQ_IDLE)
		begin
			next_r.highPhase = !r.highPhase; // [R4]
			if (!r.highPhase)
				next_r.lowByte = hostWrData;
		end
		if (seqWe)
		begin
			next_r.seqLen = r.seqLen + 1'b1; // [R3]
			if (r.lowByte[7] && !r.markSeen)
			begin
				next_r.markIdx = r.seqLen[SW-1:0]; // [R25]
				next_r.markSeen = 1'b1;
			end
		end
		if (cmdFlushSeq && r.st == DSQ_IDLE)
		begin
			next_r.seqLen = '0;
			next_r.highPhase = 1'b0;
			next_r.markIdx = '0;
			next_r.markSeen = 1'b0;
		end
		// Status read: return word, drop events; a new event still wins
		if (hostRd)
			next_r.rdData = (hostAddr == CFG_OFS) ? stat : '0; // [R21] [R22]
		if (hostRd && hostAddr == CFG_OFS)
		begin
			next_r.evLost = 1'b0; // [R24]
			next_r.evEnd = 1'b0;
			next_r.evThr = 1'b0;
		end
		if (stat.almostFull && !r.afullPrev)
			next_r.evThr = 1'b1; // [R16]
		if (r.st == DSQ_CONVERT && convDone && !fifoReady)
			next_r.evLost = 1'b1;
		// Scan control
		unique case (r.st)
			DSQ_IDLE:
				if (cmdTrigger && r.cfg.extTrig)
					next_r.st = DSQ_ARMED; // [R19]
			DSQ_ARMED: ;
			DSQ_FETCH:
				next_r.st = DSQ_LOAD;
			DSQ_LOAD:
			begin
				next_r.entry = dsq_entry_s'(memQ);
				next_r.convStart = 1'b1;
				next_r.st = DSQ_CONVERT;
			end
			DSQ_CONVERT:
				if (convDone)
				begin
					if (!lastEntry)
					begin
						next_r.idx = r.idx + 1'b1; // [R25]
						next_r.st = DSQ_FETCH;
					end
					else
					begin
						next_r.evEnd = 1'b1; // [R16]
						next_r.st = r.cfg.continuous ? DSQ_PACE : DSQ_IDLE; // [R17] [R18]
						next_r.triggered = r.cfg.continuous;
					end
				end
			DSQ_PACE:
				if (pacerTick)
				begin
					next_r.idx = r.markIdx; // [R18]
					next_r.st = DSQ_FETCH;
				end
		endcase
		if (startPass && r.seqLen != '0)
		begin
			next_r.idx = r.markIdx; // [R25]
			next_r.triggered = 1'b1;
			next_r.st = DSQ_FETCH; // [R17]
		end
		if (cmdStop && r.st != DSQ_IDLE)
		begin
			next_r.st = DSQ_IDLE; // [R18]
			next_r.triggered = 1'b0;
		end
		// Interrupt from latched events and enables
		next_r.intReq = (next_r.evEnd && next_r.cfg.endIntEn)
			|| (next_r.evThr && next_r.cfg.thrIntEn); // [R14] [R15]
		// Expansion mode takes over the digital outputs
		next_r.digOut = next_r.cfg.expMode ? next_r.entry.extChannel : digOutLatch; // [R13]
		// Registered so the pins never glitch while an entry loads
		next_r.groundIn = next_r.entry.diffMode && (next_r.entry.channel >= GND_CH_MIN); // [R10]
		next_r.expGain = next_r.cfg.expMode ? next_r.entry.extGain : 2'h0; // [R9] [R13]
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r <= '0;
			r.st <= DSQ_IDLE;
			r.cfg <= dsq_cfg_s'(CFG_RESET);
		end
		else if (ce)
			r <= next_r;
	end

	// ==========================================
	// Sequence memory: synchronous write and read
	always_ff @(posedge core_clk)
	begin
		if (ce && seqWe)
			seqMem[r.seqLen[SW-1:0]] <= {hostWrData, r.lowByte}; // [R3]
		if (ce)
			memQ <= seqMem[r.idx];
	end

	// ==========================================
	// Outputs, all from flops
	assign hostRdData = r.rdData;
	assign intReq = r.intReq;
	assign convStart = r.convStart;
	assign adcChannel = r.entry.channel; // [R7]
	assign adcGain = r.entry.gain; // [R6]
	assign diffMode = r.entry.diffMode; // [R5]
	assign groundInput = r.groundIn; // [R10]
	assign digOut = r.digOut;
	// Gain lines only leave the card in expansion mode
	assign expGainOut = r.expGain; // [R9] [R13]
	assign expGainOe = r.cfg.expMode; // [R13]
	assign pacerSource = r.cfg.pacerSrc; // [R12]

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_empty_flags: assert property ( // [R1]
		ce && hostRd && hostAddr == CFG_OFS && fill == '0
		|=> hostRdData[0] && !hostRdData[1] && !hostRdData[2])
		else $error("empty flags wrong");
	chk_full_flags: assert property ( // [R2]
		ce && hostRd && hostAddr == CFG_OFS && fill == (FW+1)'(FIFO_WORDS)
		|=> hostRdData[2] && hostRdData[1] && !hostRdData[0])
		else $error("full flags wrong");
	chk_ground_input: assert property ( // [R10]
		diffMode && adcChannel[3] |-> groundInput)
		else $error("input not grounded");
	chk_entry_decode: assert property ( // [R6]
		ce && r.st == DSQ_LOAD |=> adcGain == $past(memQ[13:12])
		&& adcChannel == $past(memQ[11:8]) && convStart)
		else $error("entry fields wrong");
	chk_exp_ignored: assert property ( // [R9]
		!r.cfg.expMode |-> expGainOut == 2'h0 && !expGainOe)
		else $error("expansion lines driven");
	chk_event_clear: assert property ( // [R24]
		ce && hostRd && hostAddr == CFG_OFS && !(stat.almostFull && !r.afullPrev)
		&& !(r.st == DSQ_CONVERT && convDone) |=> !r.evThr && !r.evEnd && !r.evLost)
		else $error("events not cleared");
	chk_int_mask: assert property ( // [R14]
		ce && !hostWr && !r.cfg.endIntEn && !r.cfg.thrIntEn |=> !intReq)
		else $error("masked interrupt raised");
	chk_oneshot_idle: assert property ( // [R17]
		ce && r.st == DSQ_CONVERT && convDone && lastEntry && !r.cfg.continuous
		&& !cmdStop |=> r.st == DSQ_IDLE && r.evEnd)
		else $error("one-shot did not end");
	chk_pacer_src: assert property ( // [R12]
		ce && hostWr && hostAddr == CFG_OFS |=> pacerSource == $past(hostWrData[7:6]))
		else $error("pacer source not taken");

	chk_seq_store: assert property ( // [R3]
		ce && seqWe |=> r.seqLen == $past(r.seqLen) + 1'b1)
		else $error("entry not stored");
endmodule
`default_nettype wire

// ==== tb/dsq_adc_model.sv ====
// Behavioural converter that answers each start pulse with one result
`timescale 1ns/10ps
`default_nettype none
module dsq_adc_model
#(
	parameter int LAT = 2
)(
	input wire logic core_clk, // Clock
	input wire logic nrst, // Async reset, low
	input wire logic convStart, // Start pulse
	output logic convDone, // Result pulse
	output logic [15:0] convData // Result word
);
	// ==========================================
	// Conversion timing
	int wait_cnt;
	logic [15:0] seqNo;
	// Data wanders between results so a stale word is never mistaken for valid
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wait_cnt <= 0;
			seqNo <= 16'hC000;
			convDone <= 1'b0;
			convData <= 16'h0000;
		end
		else
		begin
			convDone <= 1'b0;
			convData <= ~convData;
			if (convStart)
				wait_cnt <= LAT;
			else if (wait_cnt == 1)
			begin
				wait_cnt <= 0;
				convDone <= 1'b1;
				convData <= seqNo;
				seqNo <= seqNo + 16'h0001;
			end
			else if (wait_cnt > 1)
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Register-level testbench for the scan sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import dsq_pkg::*;
	// ==========================================
	// Stimulus and wiring
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic [2:0] hostAddr = 3'h0;
	logic [7:0] hostWrData = 8'h00;
	logic hostWr = 1'b0;
	logic hostRd = 1'b0;
	logic [7:0] hostRdData;
	logic [3:0] cmds = 4'h0;
	logic extTrigIn = 1'b1;
	logic pacerTick = 1'b0;
	logic convStart, convDone, diffMode, groundInput, expGainOe, sampleValid, intReq;
	logic [15:0] convData, sampleData;
	logic [3:0] adcChannel, digOut;
	logic [1:0] adcGain, expGainOut, pacerSource;
	logic sampleReady = 1'b0;
	logic [7:0] seen[$];
	logic [7:0] expDec[3] = '{8'h10, 8'h2C, 8'hC9};
	int err_total = 0;
	int cmp_count = 0;
	int n;
	always #25 core_clk = ~core_clk;
	dsq_sequencer #(.SEQ_WORDS(16), .FIFO_WORDS(8), .THR_BYTES(7)) dsq_sequencer_i (
		.core_clk(core_clk), .nrst(nrst), .ce(ce), .hostAddr(hostAddr),
		.hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
		.cmdTrigger(cmds[0]), .cmdStop(cmds[1]), .cmdFlushSeq(cmds[2]),
		.cmdFlushData(cmds[3]), .extTrigIn(extTrigIn), .pacerTick(pacerTick),
		.convStart(convStart), .convDone(convDone), .convData(convData),
		.adcChannel(adcChannel), .adcGain(adcGain), .diffMode(diffMode),
		.groundInput(groundInput), .digOutLatch(4'h5), .digOut(digOut),
		.expGainOut(expGainOut), .expGainOe(expGainOe), .pacerSource(pacerSource),
		.sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady),
		.intReq(intReq));
	dsq_adc_model dsq_adc_model_i (.core_clk(core_clk), .nrst(nrst), .convStart(convStart),
		.convDone(convDone), .convData(convData));
	// Record the entry decode seen with each conversion start
	always @(posedge core_clk)
		if (convStart === 1'b1)
			seen.push_back({groundInput, diffMode, adcGain, adcChannel});
	// ==========================================
	// Host access tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		hostAddr <= a;
		hostWrData <= d;
		hostWr <= 1'b1;
		@(posedge core_clk);
		hostWr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		hostAddr <= a;
		hostRd <= 1'b1;
		@(posedge core_clk);
		hostRd <= 1'b0;
		@(posedge core_clk);
		check({8'h00, hostRdData}, {8'h00, exp});
	endtask
	task automatic cmd(input int k);
		@(posedge core_clk);
		cmds <= 4'h1 << k;
		@(posedge core_clk);
		cmds <= 4'h0;
	endtask
	// Bounded wait for a pass to finish its starts, then let the last result land
	task automatic run_pass(input int total);
		for (int i = 0; i < 300 && seen.size() < total; i++)
			@(posedge core_clk);
		repeat (12) @(posedge core_clk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// Watchdog sized well past the expected run
	initial
	begin
		#(20000 * 50);
		err_total++;
		finish_test();
	end
	// ==========================================
	// Test sequence
	initial
	begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		rd(CFG_OFS, 8'h81);
		rd(3'h3, 8'h00);
		cmd(2);
		// Low byte first, first entry marked
		wr(SEQ_PORT_OFS, 8'h80);
		wr(SEQ_PORT_OFS, 8'h10);
		wr(SEQ_PORT_OFS, 8'h00);
		wr(SEQ_PORT_OFS, 8'h2C);
		wr(SEQ_PORT_OFS, 8'h26);
		wr(SEQ_PORT_OFS, 8'h49);
		cmd(3);
		wr(CFG_OFS, 8'h40);
		@(posedge core_clk);
		check({14'h0, pacerSource}, 16'h0001);
		check({8'h0, expGainOe, 1'b0, expGainOut, digOut}, 16'h0005);
		// Clock enable low: a control write must leave no trace
		ce <= 1'b0;
		wr(CFG_OFS, 8'hC0);
		ce <= 1'b1;
		@(posedge core_clk);
		check({14'h0, pacerSource}, 16'h0001);
		cmd(0);
		run_pass(3);
		check(seen.size(), 3);
		rd(CFG_OFS, 8'h90);
		rd(CFG_OFS, 8'h80);
		// Second pass with both interrupts off: events still latch
		cmd(0);
		run_pass(6);
		check({15'h0, intReq}, 16'h0000);
		wr(CFG_OFS, 8'h50);
		repeat (2) @(posedge core_clk);
		check({15'h0, intReq}, 16'h0001);
		wr(CFG_OFS, 8'h48);
		repeat (2) @(posedge core_clk);
		check({15'h0, intReq}, 16'h0001);
		wr(CFG_OFS, 8'h40);
		repeat (2) @(posedge core_clk);
		check({15'h0, intReq}, 16'h0000);
		rd(CFG_OFS, 8'h9A);
		// External falling edge: arming alone must not start a pass
		wr(CFG_OFS, 8'h43);
		cmd(0);
		repeat (6) @(posedge core_clk);
		check(seen.size(), 6);
		extTrigIn <= 1'b0;
		run_pass(9);
		check(seen.size(), 9);
		rd(CFG_OFS, 8'hB6);
		foreach (seen[i])
			check({8'h0, seen[i]}, {8'h0, expDec[i % 3]});
		// Drain in arrival order; the ninth result was dropped while full
		sampleReady <= 1'b1;
		n = 0;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			if (sampleValid === 1'b1)
			begin
				check(sampleData, 16'hC000 + n[15:0]);
				n++;
			end
		end
		check(n[15:0], 16'h0008);
		rd(CFG_OFS, 8'h81);
		// Expansion mode: last entry's external fields reach the pins
		wr(CFG_OFS, 8'h60);
		@(posedge core_clk);
		check({8'h0, expGainOe, 1'b0, expGainOut, digOut}, 16'h00A6);
		finish_test();
	end
endmodule
`default_nettype wire
